/* bdsr_chk.sv */
`timescale 1ns/1ps
module bdsr_chk (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [bdsr_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic i_enable,
    input wire logic i_fwd_shift_pulse,
    input wire logic i_bwd_shift_pulse,
    input wire logic i_clear_all_stages,
    input wire logic i_fwd_bit_in,
    input wire logic i_bwd_bit_in,
    input wire logic signed [31:0] i_fwd_word_in,
    input wire logic signed [31:0] i_bwd_word_in,
    input wire logic [bdsr_pkg::STAGES-1:0] o_bit_stage_out,
    input wire logic [bdsr_pkg::STAGES-1:0][bdsr_pkg::WORD_W-1:0] o_word_stage_out
);
    logic gate_reg;
    logic mode_reg;
    wire ctrl_wr = i_psel && i_penable && o_pready && i_pwrite && i_paddr == bdsr_pkg::CTRL_ADDR;
    wire act = !gate_reg || i_enable;
    wire quiet = act && !i_clear_all_stages;
    // shadow of the control register
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            gate_reg <= 1'b1;
            mode_reg <= 1'b0;
        end else if (ctrl_wr) begin
            gate_reg <= i_pwdata[0];
            mode_reg <= i_pwdata[1];
        end
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    property p_rst; $rose(i_rstn) |-> o_bit_stage_out == 0 && o_word_stage_out == 0; endproperty
    a_rst: assert property (p_rst) else $error("stages not zero after reset");
    property p_clr;
        (i_clear_all_stages && act) [*5] |-> o_bit_stage_out == 0 && o_word_stage_out == 0;
    endproperty
    a_clr: assert property (p_clr) else $error("clear did not zero stages");
    property p_fb;
        $rose(i_fwd_shift_pulse) && quiet && !mode_reg |->
            ##3 o_bit_stage_out == {$past(o_bit_stage_out[6:0]), $past(i_fwd_bit_in, 3)};
    endproperty
    a_fb: assert property (p_fb) else $error("bad forward bit step");
    property p_bb;
        $rose(i_bwd_shift_pulse) && quiet && !mode_reg |->
            ##3 o_bit_stage_out == {$past(i_bwd_bit_in, 3), $past(o_bit_stage_out[7:1])};
    endproperty
    a_bb: assert property (p_bb) else $error("bad backward bit step");
    property p_fw;
        $rose(i_fwd_shift_pulse) && quiet && mode_reg |->
            ##3 o_word_stage_out == {$past(o_word_stage_out[6:0]), $past(i_fwd_word_in, 3)};
    endproperty
    a_fw: assert property (p_fw) else $error("bad forward word step");
    property p_bw;
        $rose(i_bwd_shift_pulse) && quiet && mode_reg |->
            ##3 o_word_stage_out == {$past(i_bwd_word_in, 3), $past(o_word_stage_out[7:1])};
    endproperty
    a_bw: assert property (p_bw) else $error("bad backward word step");
    property p_inert;
        $rose(i_fwd_shift_pulse) && !mode_reg && !i_clear_all_stages |->
            ##3 $stable(o_word_stage_out);
    endproperty
    a_inert: assert property (p_inert) else $error("word stages moved in bit mode");
    property p_gate;
        ($rose(i_fwd_shift_pulse) || $rose(i_bwd_shift_pulse)) && !act |->
            ##3 $stable(o_bit_stage_out) && $stable(o_word_stage_out);
    endproperty
    a_gate: assert property (p_gate) else $error("step taken while disabled");
endmodule // bdsr_chk
bind bdsr_shift_block bdsr_chk chk_u (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_pready(o_pready),
    .i_enable(i_enable),
    .i_fwd_shift_pulse(i_fwd_shift_pulse),
    .i_bwd_shift_pulse(i_bwd_shift_pulse),
    .i_clear_all_stages(i_clear_all_stages),
    .i_fwd_bit_in(i_fwd_bit_in),
    .i_bwd_bit_in(i_bwd_bit_in),
    .i_fwd_word_in(i_fwd_word_in),
    .i_bwd_word_in(i_bwd_word_in),
    .o_bit_stage_out(o_bit_stage_out),
    .o_word_stage_out(o_word_stage_out)
);

/* bdsr_ctl_model.sv */
`timescale 1ns/1ps
module bdsr_ctl_model (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_go,
    input wire logic i_dir,
    input wire logic i_bit,
    input wire logic [31:0] i_word,
    output logic o_fwd_shift_pulse,
    output logic o_bwd_shift_pulse,
    output logic o_fwd_bit_in,
    output logic o_bwd_bit_in,
    output logic [31:0] o_fwd_word_in,
    output logic [31:0] o_bwd_word_in,
    output logic o_busy
);
    logic [3:0] cnt_reg;
    logic dir_reg;
    logic bit_reg;
    logic [31:0] word_reg;
    // data leads the pulse by two cycles and outlasts its edge
    wire pulse = cnt_reg > 4'h2 && cnt_reg < 4'h6;
    assign o_busy = cnt_reg != 4'h0;
    assign o_fwd_shift_pulse = pulse && !dir_reg;
    assign o_bwd_shift_pulse = pulse && dir_reg;
    // unused direction carries inverted data
    assign o_fwd_bit_in = bit_reg ^ dir_reg;
    assign o_bwd_bit_in = bit_reg ^ !dir_reg;
    assign o_fwd_word_in = dir_reg ? ~word_reg : word_reg;
    assign o_bwd_word_in = dir_reg ? word_reg : ~word_reg;
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_reg <= 4'h0;
            dir_reg <= 1'b0;
            bit_reg <= 1'b0;
            word_reg <= 32'h0000_0000;
        end else if (i_go && !o_busy) begin
            cnt_reg <= 4'h1;
            dir_reg <= i_dir;
            bit_reg <= i_bit;
            word_reg <= i_word;
        end else if (o_busy) begin
            cnt_reg <= cnt_reg == 4'h8 ? 4'h0 : cnt_reg + 4'h1;
        end
    end
endmodule // bdsr_ctl_model

/* bdsr_edge.sv */
`timescale 1ns/1ps
module bdsr_edge #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic [WIDTH-1:0] i_level,
    output logic [WIDTH-1:0] o_rise
);

    logic [WIDTH-1:0] prev_reg;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= i_level;
        end
    end

    // high for one cycle when the level goes from 0 to 1
    assign o_rise = i_level & ~prev_reg;

endmodule // bdsr_edge

/* bdsr_pkg.sv */
package bdsr_pkg;

    localparam int unsigned STAGES = 8;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned ADDR_W = 8;

    // register byte addresses
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] CMD_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;
    localparam logic [2:0] WORD_BANK_SEL = 3'h1;

    // control register fields
    localparam int unsigned CTRL_EN_GATE_BIT = 0;
    localparam int unsigned CTRL_DWORD_BIT = 1;
    localparam logic CTRL_EN_GATE_RST = 1'b1;
    localparam logic CTRL_DWORD_RST = 1'b0;

    // command register fields, write-one pulses
    localparam int unsigned CMD_FWD_BIT = 0;
    localparam int unsigned CMD_BWD_BIT = 1;
    localparam int unsigned CMD_CLEAR_BIT = 2;

    // status register fields
    localparam int unsigned STAT_ACTIVE_BIT = 8;
    localparam int unsigned STAT_DWORD_BIT = 9;

    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // operating modes
    typedef enum logic {
        BDSR_MODE_BIT = 1'b0,
        BDSR_MODE_DWORD = 1'b1
    } bdsr_mode_t;

endpackage

/* bdsr_shift_block.sv */
`timescale 1ns/1ps
// Operation
// - with gating on, act only while enabled
// - option selects whether enable is evaluated
// - option off means permanently enabled
// - clear level zeroes all bit and word stages
// - forward pulse rising edge shifts forward
// - backward pulse rising edge shifts backward
// - bit mode takes forward/backward bit inputs
// - word inputs are 32-bit signed values
// - bit and dword modes, bit by default
// - word ports inert in bit mode
// - eight bit stage outputs
// - eight signed 32-bit word stage outputs; the word output port is declared without signed
// - no retention, stages start cleared
// - dword forward moves stage n to n+1
// - bit forward loads stage 1, drops 8
// - bit backward loads stage 8, drops 1
// - dword forward loads forward word into stage 1
// - dword backward loads backward word into stage 8
module bdsr_shift_block (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [bdsr_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // control pins
    input wire logic i_enable,
    input wire logic i_fwd_shift_pulse,
    input wire logic i_bwd_shift_pulse,
    input wire logic i_clear_all_stages,
    input wire logic i_fwd_bit_in,
    input wire logic i_bwd_bit_in,
    input wire logic signed [31:0] i_fwd_word_in,
    input wire logic signed [31:0] i_bwd_word_in,
    // stage outputs, index 0 is stage 1
    output logic [bdsr_pkg::STAGES-1:0] o_bit_stage_out,
    output logic [bdsr_pkg::STAGES-1:0][bdsr_pkg::WORD_W-1:0] o_word_stage_out
);

    localparam int unsigned SYNC_W = 6 + 2 * bdsr_pkg::WORD_W;
    localparam int unsigned LAST = bdsr_pkg::STAGES - 1;

    // ---------------- pin synchronisation ----------------
    logic [SYNC_W-1:0] pins_async;
    logic [SYNC_W-1:0] pins_sync;
    logic enable_s;
    logic fwd_pulse_s;
    logic bwd_pulse_s;
    logic clear_s;
    logic fwd_bit_s;
    logic bwd_bit_s;
    logic signed [31:0] fwd_word_s;
    logic signed [31:0] bwd_word_s;

    assign pins_async = {i_enable, i_fwd_shift_pulse, i_bwd_shift_pulse, i_clear_all_stages,
                         i_fwd_bit_in, i_bwd_bit_in, i_fwd_word_in, i_bwd_word_in};

    // data and pulses share the same two-stage delay, keeping them aligned
    bdsr_sync #(
        .WIDTH(SYNC_W)
    ) u_pin_sync (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_async(pins_async),
        .o_sync(pins_sync)
    );

    assign enable_s = pins_sync[SYNC_W-1];
    assign fwd_pulse_s = pins_sync[SYNC_W-2];
    assign bwd_pulse_s = pins_sync[SYNC_W-3];
    assign clear_s = pins_sync[SYNC_W-4];
    assign fwd_bit_s = pins_sync[SYNC_W-5];
    assign bwd_bit_s = pins_sync[SYNC_W-6];
    assign fwd_word_s = pins_sync[2*bdsr_pkg::WORD_W-1:bdsr_pkg::WORD_W];
    assign bwd_word_s = pins_sync[bdsr_pkg::WORD_W-1:0];

    // ---------------- pulse edge detection ----------------
    logic [1:0] pulse_rise;

    bdsr_edge #(
        .WIDTH(2)
    ) u_pulse_edge (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_level({fwd_pulse_s, bwd_pulse_s}),
        .o_rise(pulse_rise)
    );

    // ---------------- apb decode ----------------
    logic ctrl_en_gate_reg;
    logic ctrl_en_gate_next;
    logic ctrl_dword_reg;
    logic ctrl_dword_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pslverr_reg;
    logic pslverr_next;

    wire setup_phase = i_psel & ~i_penable;
    wire wr_commit = i_psel & i_penable & pready_reg & i_pwrite & ~pslverr_reg;
    wire addr_aligned = (i_paddr[1:0] == 2'h0);
    wire hit_ctrl = addr_aligned & (i_paddr == bdsr_pkg::CTRL_ADDR);
    wire hit_cmd = addr_aligned & (i_paddr == bdsr_pkg::CMD_ADDR);
    wire hit_status = addr_aligned & (i_paddr == bdsr_pkg::STATUS_ADDR);
    wire hit_word = addr_aligned & (i_paddr[7:5] == bdsr_pkg::WORD_BANK_SEL);
    wire [2:0] word_idx = i_paddr[4:2];
    wire addr_valid = hit_ctrl | hit_cmd | hit_status | hit_word;
    // status and word bank are read-only; command reads as zero
    wire wr_illegal = i_pwrite & (hit_status | hit_word);
    wire ctrl_wr = wr_commit & hit_ctrl & i_pstrb[0];
    wire cmd_wr = wr_commit & hit_cmd & i_pstrb[0];

    wire sw_fwd = cmd_wr & i_pwdata[bdsr_pkg::CMD_FWD_BIT];
    wire sw_bwd = cmd_wr & i_pwdata[bdsr_pkg::CMD_BWD_BIT];
    wire sw_clear = cmd_wr & i_pwdata[bdsr_pkg::CMD_CLEAR_BIT];

    assign ctrl_en_gate_next = ctrl_wr ? i_pwdata[bdsr_pkg::CTRL_EN_GATE_BIT] : ctrl_en_gate_reg;
    assign ctrl_dword_next = ctrl_wr ? i_pwdata[bdsr_pkg::CTRL_DWORD_BIT] : ctrl_dword_reg;

    // ---------------- activity and mode ----------------
    bdsr_pkg::bdsr_mode_t mode;
    assign mode = bdsr_pkg::bdsr_mode_t'(ctrl_dword_reg);

    // gating option off: enable pin ignored, block always active
    wire block_active = ~ctrl_en_gate_reg | enable_s;

    wire do_clear = block_active & (clear_s | sw_clear);
    wire fwd_req = block_active & (pulse_rise[1] | sw_fwd);
    wire bwd_req = block_active & (pulse_rise[0] | sw_bwd);
    // clear beats any shift; forward beats backward in the same cycle
    wire do_fwd = ~do_clear & fwd_req;
    wire do_bwd = ~do_clear & ~fwd_req & bwd_req;
    wire bit_mode = (mode == bdsr_pkg::BDSR_MODE_BIT);

    // ---------------- bit stages ----------------
    logic [bdsr_pkg::STAGES-1:0] bit_stage_reg;
    logic [bdsr_pkg::STAGES-1:0] bit_stage_next;
    wire [bdsr_pkg::STAGES-1:0] bit_fwd_val = {bit_stage_reg[LAST-1:0], fwd_bit_s};
    wire [bdsr_pkg::STAGES-1:0] bit_bwd_val = {bwd_bit_s, bit_stage_reg[LAST:1]};

    always_comb begin
        bit_stage_next = bit_stage_reg;
        if (do_clear) begin
            bit_stage_next = '0;
        end else if (bit_mode && do_fwd) begin
            bit_stage_next = bit_fwd_val;
        end else if (bit_mode && do_bwd) begin
            bit_stage_next = bit_bwd_val;
        end
    end

    // stages are plain flops reset to zero, nothing retained
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bit_stage_reg <= '0;
        end else begin
            bit_stage_reg <= bit_stage_next;
        end
    end

    assign o_bit_stage_out = bit_stage_reg;

    // ---------------- word stages ----------------
    logic [bdsr_pkg::STAGES-1:0][bdsr_pkg::WORD_W-1:0] word_stage_reg;
    logic [bdsr_pkg::STAGES-1:0][bdsr_pkg::WORD_W-1:0] word_stage_next;
    // word stages only move in dword mode
    wire word_fwd = ~bit_mode & do_fwd;
    wire word_bwd = ~bit_mode & do_bwd;

    genvar g;
    generate
        for (g = 0; g < bdsr_pkg::STAGES; g++) begin : g_word_stage
            logic [bdsr_pkg::WORD_W-1:0] from_lower;
            logic [bdsr_pkg::WORD_W-1:0] from_upper;
            if (g == 0) begin : g_first
                assign from_lower = fwd_word_s;
            end else begin : g_mid_lo
                assign from_lower = word_stage_reg[g-1];
            end
            if (g == LAST) begin : g_last
                assign from_upper = bwd_word_s;
            end else begin : g_mid_hi
                assign from_upper = word_stage_reg[g+1];
            end
            assign word_stage_next[g] = do_clear ? '0 :
                word_fwd ? from_lower :
                word_bwd ? from_upper :
                word_stage_reg[g];
        end
    endgenerate

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            word_stage_reg <= '0;
        end else begin
            word_stage_reg <= word_stage_next;
        end
    end

    assign o_word_stage_out = word_stage_reg;

    // ---------------- control register ----------------
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_en_gate_reg <= bdsr_pkg::CTRL_EN_GATE_RST;
            ctrl_dword_reg <= bdsr_pkg::CTRL_DWORD_RST;
        end else begin
            ctrl_en_gate_reg <= ctrl_en_gate_next;
            ctrl_dword_reg <= ctrl_dword_next;
        end
    end

    // ---------------- read path ----------------
    logic [31:0] ctrl_rd;
    logic [31:0] status_rd;

    // fields placed by the package bit positions, unused bits read zero
    always_comb begin
        ctrl_rd = '0;
        ctrl_rd[bdsr_pkg::CTRL_EN_GATE_BIT] = ctrl_en_gate_reg;
        ctrl_rd[bdsr_pkg::CTRL_DWORD_BIT] = ctrl_dword_reg;
    end

    always_comb begin
        status_rd = '0;
        status_rd[bdsr_pkg::STAGES-1:0] = bit_stage_reg;
        status_rd[bdsr_pkg::STAT_ACTIVE_BIT] = block_active;
        status_rd[bdsr_pkg::STAT_DWORD_BIT] = ctrl_dword_reg;
    end

    wire [31:0] word_rd = word_stage_reg[word_idx];

    always_comb begin
        prdata_next = bdsr_pkg::RDATA_RST;
        if (setup_phase && !i_pwrite) begin
            if (hit_ctrl) begin
                prdata_next = ctrl_rd;
            end else if (hit_status) begin
                prdata_next = status_rd;
            end else if (hit_word) begin
                prdata_next = word_rd;
            end
        end
    end

    assign pslverr_next = setup_phase & (~addr_valid | wr_illegal);

    // one wait-free access cycle: answer is ready in the first access cycle
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prdata_reg <= bdsr_pkg::RDATA_RST;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg <= prdata_next;
            pready_reg <= setup_phase;
            pslverr_reg <= pslverr_next;
        end
    end

    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;

endmodule // bdsr_shift_block

/* bdsr_sync.sv */
`timescale 1ns/1ps
module bdsr_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule // bdsr_sync

/* tb_bit_dword_shift_register.sv */
`timescale 1ns/1ps
module tb_bit_dword_shift_register;
    logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, en = 0, clr = 0;
    logic go = 0, dir = 0, bi = 0, pready, pslverr, er, fp, bp, fb, bb, busy;
    logic [7:0] paddr = 0, qb;
    logic [31:0] pwdata = 0, w = 0, prdata, rd, fw, bw;
    logic [7:0][31:0] qw;
    int mb[8], mw[8], mismatches = 0, comparisons = 0;
    bit gate = 1, mode = 0;
    always #5 clk = !clk;
    bdsr_shift_block dut_u (.i_core_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_enable(en), .i_fwd_shift_pulse(fp),
        .i_bwd_shift_pulse(bp), .i_clear_all_stages(clr), .i_fwd_bit_in(fb), .i_bwd_bit_in(bb),
        .i_fwd_word_in(fw), .i_bwd_word_in(bw), .o_bit_stage_out(qb), .o_word_stage_out(qw));
    bdsr_ctl_model ctl_u (.i_core_clk(clk), .i_rstn(rstn), .i_go(go), .i_dir(dir), .i_bit(bi),
        .i_word(w), .o_fwd_shift_pulse(fp), .o_bwd_shift_pulse(bp), .o_fwd_bit_in(fb),
        .o_bwd_bit_in(bb), .o_fwd_word_in(fw), .o_bwd_word_in(bw), .o_busy(busy));
    task automatic cmp(input logic [255:0] got, input logic [255:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 9);
        if (pready !== 1'b1) mismatches++;
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    function automatic logic [255:0] ew();
        for (int i = 0; i < 8; i++) ew[i*32+:32] = mw[i];
    endfunction
    function automatic logic [7:0] eb();
        for (int i = 0; i < 8; i++) eb[i] = mb[i][0];
    endfunction
    task automatic shift(ref int a[8], input bit d, input int v);
        for (int i = 0; i < 7; i++) begin
            if (d) a[i] = a[i+1];
            else a[7-i] = a[6-i];
        end
        a[d ? 7 : 0] = v;
    endtask
    task automatic step(input bit d, input logic [31:0] v, input bit b);
        int n = 0;
        @(posedge clk);
        go <= 1;
        dir <= d;
        w <= v;
        bi <= b;
        @(posedge clk);
        go <= 0;
        do @(posedge clk); while (busy !== 1'b0 && ++n < 20);
        if (busy !== 1'b0) mismatches++;
        if ((!gate || en) && !clr) begin
            if (mode) shift(mw, d, v);
            else shift(mb, d, b);
        end
        cmp(qb, eb());
        cmp(qw, ew());
    endtask
    task automatic burst(input int k);
        for (int i = 0; i < k; i++)
            step(1'($urandom), i == 0 ? 32'h8000_0000 : i == 1 ? 32'h7FFF_FFFF : $urandom,
                 1'($urandom));
    endtask
    task automatic test_done;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #300us;
        mismatches++;
        test_done;
    end
    initial begin
        void'($urandom(21));
        repeat (3) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        cmp(qb, 0);
        cmp(qw, 0);
        apb(0, bdsr_pkg::CTRL_ADDR, 0);
        cmp(rd[1:0], 2'h1);
        en <= 1;
        burst(10);
        en <= 0;
        burst(3);
        clr <= 1;
        repeat (6) @(posedge clk);
        clr <= 0;
        apb(1, bdsr_pkg::CTRL_ADDR, 0);
        gate = 0;
        burst(3);
        apb(1, bdsr_pkg::CTRL_ADDR, 32'h3);
        gate = 1;
        mode = 1;
        en <= 1;
        burst(12);
        apb(0, bdsr_pkg::STATUS_ADDR, 0);
        cmp(rd[9:0], {2'h3, eb()});
        for (int i = 0; i < 8; i++) begin
            apb(0, 8'h20 + 8'(4 * i), 0);
            cmp({er, rd}, {1'b0, 32'(mw[i])});
        end
        apb(0, 8'h40, 0);
        cmp(er, 1);
        apb(1, bdsr_pkg::CMD_ADDR, 32'h1);
        shift(mw, 0, fw);
        @(posedge clk);
        cmp(qw, ew());
        apb(1, bdsr_pkg::CMD_ADDR, 32'h2);
        shift(mw, 1, bw);
        @(posedge clk);
        cmp(qw, ew());
        clr <= 1;
        repeat (6) @(posedge clk);
        mb = '{default: 0};
        mw = '{default: 0};
        cmp(qb, 0);
        cmp(qw, 0);
        step(0, $urandom, 1);
        clr <= 0;
        test_done;
    end
endmodule // tb_bit_dword_shift_register
